// [paged_flash_serial_front_end_test.sv]
`timescale 1ns/1ps
`default_nettype none

module paged_flash_serial_front_end_test;
  logic        clk, rst_b, hw_reset_b, wp_b, sclk, cs_b, mosi, miso, miso_oe;
  logic        buf_we, rd_req, cyc_erase, cyc_program, cyc_sector, cyc_abort;
  logic        write_permit_latch, busy, active, standby;
  logic [11:0] cyc_page;
  logic [19:0] rd_addr;
  logic [7:0]  rd_data = 8'h00;
  logic [7:0]  buf_col, buf_data, last_col, last_dat;
  logic        miso_pin;
  int          err_count, total_checks, nwe, nab, noe;

  pfsfe_top #(.ERASE_CLKS(20), .PROGRAM_CLKS(10)) u_pfsfe_top (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .mosi(mosi),
    .hw_reset_b(hw_reset_b), .wp_b(wp_b), .miso(miso), .miso_oe(miso_oe),
    .buf_we(buf_we), .buf_col(buf_col), .buf_data(buf_data), .rd_req(rd_req),
    .rd_addr(rd_addr),
    .rd_data(rd_data), .cyc_erase(cyc_erase), .cyc_program(cyc_program),
    .cyc_sector(cyc_sector), .cyc_page(cyc_page), .cyc_abort(cyc_abort),
    .write_permit_latch(write_permit_latch), .busy(busy), .active(active),
    .standby(standby));

  // no pull on the data-out line: a floating line reads as the inverse
  assign miso_pin = miso_oe ? miso : ~miso;

  pfsfe_master u_pfsfe_master (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso_pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // array answers one cycle after the request with a pattern of its address
  always @(posedge clk) begin
    if (rd_req) rd_data <= rd_addr[7:0] ^ 8'h5A;
    nwe += buf_we;
    if (buf_we) begin
      last_col = buf_col;
      last_dat = buf_data;
    end
    nab += cyc_abort;
    noe += miso_oe;
  end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic fr(input logic [7:0] b[$], input int n);
    u_pfsfe_master.frame(b, n);
  endtask

  task automatic settle();
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    chk(busy, 1'b0);
    repeat (2) @(negedge clk);
  endtask

  task automatic t_program();
    fr('{8'h06}, 8);
    chk(write_permit_latch, 1'b1);
    nwe = 0;
    fr('{8'h02, 8'h00, 8'h35, 8'h00, 8'hAB, 8'hCD}, 48);
    chk(nwe[19:0], 20'h2);
    chk({last_col, last_dat}, 20'h001CD);
    chk({busy, cyc_program, active, standby}, 20'hE);
    chk(cyc_page, 20'h035);
    settle();
    chk({write_permit_latch, standby}, 20'h1);
  endtask

  task automatic t_protect();
    wp_b = 1'b0;
    fr('{8'h06}, 8);
    fr('{8'h0A, 8'h00, 8'h10, 8'h00, 8'h11}, 40);
    chk(busy, 1'b0);
    wp_b = 1'b1;
    fr('{8'h06}, 8);
    fr('{8'h0A, 8'h00, 8'h10, 8'h00, 8'h11}, 40);
    chk(cyc_erase, 1'b1);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (cyc_erase === 1'b0) break;
    end
    chk(cyc_program, 1'b1);
    settle();
  endtask

  task automatic t_sector_align();
    fr('{8'h06}, 8);
    fr('{8'hD8, 8'h05, 8'h00, 8'h00}, 32);
    chk({cyc_erase, cyc_sector, cyc_page[11:8]}, 20'h35);
    settle();
    fr('{8'h06}, 8);
    fr('{8'hDB, 8'h00, 8'h50, 8'h00, 8'h00}, 33);
    chk(busy, 1'b0);
    fr('{8'h04}, 8);
    chk(write_permit_latch, 1'b0);
    fr('{8'hDB, 8'h00, 8'h50, 8'h00}, 32);
    chk(busy, 1'b0);
  endtask

  task automatic t_read();
    u_pfsfe_master.cpol = 1'b1;
    noe = 0;
    fr('{8'h03, 8'hF1, 8'h23, 8'h45, 8'h00}, 40);
    chk({12'h000, u_pfsfe_master.rx}, 20'h1F);
    chk(miso_oe, 1'b0);
    chk(noe != 0, 1'b1);
    chk(rd_addr, 20'h12346);
    u_pfsfe_master.cpol = 1'b0;
  endtask

  task automatic t_reset();
    fr('{8'h06}, 8);
    fr('{8'hDB, 8'h00, 8'h60, 8'h00}, 32);
    nab = 0;
    noe = 0;
    hw_reset_b = 1'b0;
    fr('{8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, 40);
    chk({nab[3:0], busy, write_permit_latch, noe[3:0]}, 20'h040);
    hw_reset_b = 1'b1;
    repeat (5) @(negedge clk);
    fr('{8'h06}, 8);
    chk(write_permit_latch, 1'b1);
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    hw_reset_b = 1'b1;
    wp_b = 1'b1;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    t_program();
    t_protect();
    t_sector_align();
    t_read();
    t_reset();
    end_of_test();
  end

  // whole run needs well under 100 us
  initial begin
    #500000;
    err_count++;
    end_of_test();
  end
endmodule

`default_nettype wire

// [pfsfe_master.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// serial master, clock mode 0 or 3
module pfsfe_master (
  // link
  output logic      sclk,
  output logic      cs_b,
  output logic      mosi,
  input  wire logic miso
);
  logic       cpol;
  logic [7:0] rx;

  initial begin
    cpol = 1'b0;
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end

  // clock only runs inside frames; data set while clock is low
  task automatic frame(input logic [7:0] b[$], input int n);
    sclk = cpol;
    #40;
    cs_b = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      mosi = b[i/8][7-i%8];
      #80;
      sclk = 1'b1;
      rx = {rx[6:0], miso};
      #80;
    end
    sclk = cpol;
    #40;
    cs_b = 1'b1;
    mosi = ~mosi;
    #100;
  endtask
endmodule

`default_nettype wire

// [pfsfe_sync.sv]
// Functional notes
// - serial output changes only after clock falls
// - input bits sampled on rising serial clock
// - deselected device floats its serial output
// - standby only once no internal cycle runs
// - select low makes the device active
// - no instruction before first select falling edge
// - reset pin high means normal operation
// - reset pin low floats the serial output
// - reset aborts a running write cycle
// - protect low locks the lowest 256 pages
// - protect high leaves lowest pages writable
// - either idle clock level is accepted
// - array is 16 sectors of 256 pages
// - 256-byte pages, 4096 pages, byte addressed
// - one page operation alters 1 to 256 bytes
// - page write is erase then program
// - separate page erase and sector erase
// - permit latch needed, cleared after each cycle
// - internal cycle starts when select rises
// - modify commands need whole bytes of clocks
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// constants
package pfsfe_pkg;
  localparam int unsigned SECTOR_COUNT     = 16;
  localparam int unsigned PAGES_PER_SECTOR = 256;
  localparam int unsigned PAGE_BYTES       = 256;
  localparam int unsigned PAGE_COUNT       = SECTOR_COUNT * PAGES_PER_SECTOR;
  localparam int unsigned COL_W            = 8;
  localparam int unsigned PAGE_W           = 12;
  localparam int unsigned ADDR_W           = 20;
  localparam int unsigned ADDR_BYTES       = 3;
  localparam int unsigned TIMER_W          = 16;
  localparam logic [PAGE_W-1:0] PROT_PAGE_LIMIT = 12'h100;
  localparam logic [8:0]        MAX_PAGE_BYTES  = 9'h100;
  localparam logic [1:0]        LAST_ADDR_BYTE  = 2'h2;
  localparam logic [2:0]        LAST_BIT        = 3'h7;
  // command codes
  localparam logic [7:0] OP_PERMIT_SET   = 8'h06;
  localparam logic [7:0] OP_PERMIT_CLR   = 8'h04;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_PAGE_WRITE   = 8'h0A;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_PAGE_ERASE   = 8'hDB;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  // internal cycle lengths in clk cycles
  localparam int unsigned ERASE_CLKS_DEF   = 400;
  localparam int unsigned PROGRAM_CLKS_DEF = 200;
  // synchroniser lanes
  localparam int unsigned SYNC_W  = 5;
  localparam int unsigned SY_MOSI = 0;
  localparam int unsigned SY_SCLK = 1;
  localparam int unsigned SY_WP   = 2;
  localparam int unsigned SY_CS   = 3;
  localparam int unsigned SY_HRST = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h08;
  localparam int unsigned CY_ERASE_BIT   = 1;
  localparam int unsigned CY_PROGRAM_BIT = 2;
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_cmd  = 5'h02,
    st_addr = 5'h04,
    st_data = 5'h08,
    st_read = 5'h10
  } pfsfe_frame_type;
  typedef enum logic [2:0] {
    cy_idle    = 3'h1,
    cy_erase   = 3'h2,
    cy_program = 3'h4
  } pfsfe_cycle_type;
endpackage

// ==========================================================================
// two-stage synchroniser
module pfsfe_sync #(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

`default_nettype wire

// [pfsfe_top.sv]
`timescale 1ns/1ps
`default_nettype none

module pfsfe_top #(
  parameter int unsigned ERASE_CLKS   = pfsfe_pkg::ERASE_CLKS_DEF,
  parameter int unsigned PROGRAM_CLKS = pfsfe_pkg::PROGRAM_CLKS_DEF
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  // serial link pins
  input  wire logic                             sclk,
  input  wire logic                             cs_b,
  input  wire logic                             mosi,
  input  wire logic                             hw_reset_b,
  input  wire logic                             wp_b,
  output logic                                  miso,
  output logic                                  miso_oe,
  // page buffer fill
  output logic                                  buf_we,
  output logic [pfsfe_pkg::COL_W-1:0]           buf_col,
  output logic [7:0]                            buf_data,
  // array read
  output logic                                  rd_req,
  output logic [pfsfe_pkg::ADDR_W-1:0]          rd_addr,
  input  wire logic [7:0]                       rd_data,
  // internal cycle
  output logic                                  cyc_erase,
  output logic                                  cyc_program,
  output logic                                  cyc_sector,
  output logic [pfsfe_pkg::PAGE_W-1:0]          cyc_page,
  output logic                                  cyc_abort,
  // status
  output logic                                  write_permit_latch,
  output logic                                  busy,
  output logic                                  active,
  output logic                                  standby
);

  // ========================================================================
  // pin synchronisation and edges
  logic [pfsfe_pkg::SYNC_W-1:0] pins_s;
  logic                         s_mosi;
  logic                         s_sclk;
  logic                         s_wp_b;
  logic                         s_cs_b;
  logic                         s_hrst_b;
  logic                         sclk_q;
  logic                         cs_q;
  logic                         armed_q;
  logic                         normal;
  logic                         sel;
  logic                         sclk_rise;
  logic                         sclk_fall;
  logic                         cs_fall;
  logic                         cs_rise;

  // sclk and mosi share one synchroniser so they stay aligned
  pfsfe_sync #(
    .W       (pfsfe_pkg::SYNC_W),
    .RST_VAL (pfsfe_pkg::SYNC_RST)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({hw_reset_b, cs_b, wp_b, sclk, mosi}),
    .q     (pins_s)
  );

  assign s_mosi   = pins_s[pfsfe_pkg::SY_MOSI];
  assign s_sclk   = pins_s[pfsfe_pkg::SY_SCLK];
  assign s_wp_b   = pins_s[pfsfe_pkg::SY_WP];
  assign s_cs_b   = pins_s[pfsfe_pkg::SY_CS];
  assign s_hrst_b = pins_s[pfsfe_pkg::SY_HRST];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= s_sclk;
      cs_q   <= s_cs_b;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
    end else if (cs_q && !s_cs_b) begin
      armed_q <= 1'b1;
    end
  end

  assign normal    = s_hrst_b;
  assign sel       = !s_cs_b && armed_q && normal;
  // edges only, never the level: a clock idling high or low both work
  assign sclk_rise = sel && s_sclk && !sclk_q;
  assign sclk_fall = sel && !s_sclk && sclk_q;
  assign cs_fall   = cs_q && !s_cs_b && normal;
  assign cs_rise   = !cs_q && s_cs_b;

  // ========================================================================
  // input shifting
  logic [7:0]                      shift_q;
  logic [2:0]                      bit_q;
  logic [1:0]                      abyte_q;
  logic [7:0]                      byte_in;
  logic                            byte_done;
  pfsfe_pkg::pfsfe_frame_type      state_q;
  logic [7:0]                      cmd_q;
  logic [pfsfe_pkg::ADDR_W-1:0]    addr_q;
  logic [pfsfe_pkg::COL_W-1:0]     col_q;
  logic [8:0]                      nbytes_q;
  logic                            last_addr;
  logic                            cmd_needs_addr;
  logic                            cmd_fills_buf;

  assign byte_in   = {shift_q[6:0], s_mosi};
  assign byte_done = sclk_rise && (bit_q == pfsfe_pkg::LAST_BIT);
  assign last_addr = byte_done && (state_q == pfsfe_pkg::st_addr) &&
                     (abyte_q == pfsfe_pkg::LAST_ADDR_BYTE);
  assign cmd_needs_addr = (byte_in != pfsfe_pkg::OP_PERMIT_SET) &&
                          (byte_in != pfsfe_pkg::OP_PERMIT_CLR);
  assign cmd_fills_buf  = (cmd_q == pfsfe_pkg::OP_PAGE_WRITE) ||
                          (cmd_q == pfsfe_pkg::OP_PAGE_PROGRAM);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= 8'h00;
      bit_q   <= 3'h0;
    end else if (cs_fall) begin
      bit_q   <= 3'h0;
    end else if (sclk_rise) begin
      shift_q <= byte_in;
      bit_q   <= bit_q + 3'h1;
    end
  end

  // ========================================================================
  // frame sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= pfsfe_pkg::st_idle;
    end else if (!normal || s_cs_b) begin
      state_q <= pfsfe_pkg::st_idle;
    end else if (cs_fall) begin
      state_q <= pfsfe_pkg::st_cmd;
    end else if (byte_done) begin
      unique case (state_q)
        pfsfe_pkg::st_idle: begin
          state_q <= pfsfe_pkg::st_idle;
        end
        pfsfe_pkg::st_cmd: begin
          state_q <= cmd_needs_addr ? pfsfe_pkg::st_addr : pfsfe_pkg::st_data;
        end
        pfsfe_pkg::st_addr: begin
          if (abyte_q == pfsfe_pkg::LAST_ADDR_BYTE) begin
            state_q <= (cmd_q == pfsfe_pkg::OP_READ) ? pfsfe_pkg::st_read
                                                      : pfsfe_pkg::st_data;
          end
        end
        pfsfe_pkg::st_data: begin
          state_q <= pfsfe_pkg::st_data;
        end
        pfsfe_pkg::st_read: begin
          state_q <= pfsfe_pkg::st_read;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q   <= 8'h00;
      addr_q  <= 20'h00000;
      abyte_q <= 2'h0;
    end else if (cs_fall) begin
      abyte_q <= 2'h0;
    end else if (byte_done && state_q == pfsfe_pkg::st_cmd) begin
      cmd_q   <= byte_in;
    end else if (byte_done && state_q == pfsfe_pkg::st_addr) begin
      addr_q  <= {addr_q[11:0], byte_in};
      abyte_q <= abyte_q + 2'h1;
    end
  end

  // ========================================================================
  // page buffer fill, wrapping inside the addressed page
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      col_q    <= 8'h00;
      nbytes_q <= 9'h000;
      buf_we   <= 1'b0;
      buf_col  <= 8'h00;
      buf_data <= 8'h00;
    end else begin
      buf_we <= 1'b0;
      if (cs_fall) begin
        nbytes_q <= 9'h000;
      end else if (last_addr) begin
        col_q <= byte_in;
      end else if (byte_done && state_q == pfsfe_pkg::st_data && cmd_fills_buf && !busy) begin
        // later bytes overwrite from the page start; count saturates
        buf_we   <= 1'b1;
        buf_col  <= col_q;
        buf_data <= byte_in;
        col_q    <= col_q + 8'h01;
        if (nbytes_q != pfsfe_pkg::MAX_PAGE_BYTES) begin
          nbytes_q <= nbytes_q + 9'h001;
        end
      end
    end
  end

  // ========================================================================
  // read path: array answers the cycle after rd_req
  logic       rd_pend_q;
  logic [7:0] rdbuf_q;
  logic [7:0] tx_q;
  logic [2:0] obit_q;
  logic       next_fetch;

  assign next_fetch = sclk_fall && state_q == pfsfe_pkg::st_read && obit_q == 3'h0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_req    <= 1'b0;
      rd_addr   <= 20'h00000;
      rd_pend_q <= 1'b0;
      rdbuf_q   <= 8'h00;
    end else begin
      rd_req    <= 1'b0;
      rd_pend_q <= rd_req;
      if (rd_pend_q) begin
        rdbuf_q <= rd_data;
      end
      if (last_addr && cmd_q == pfsfe_pkg::OP_READ) begin
        rd_req  <= 1'b1;
        rd_addr <= {addr_q[11:0], byte_in};
      end else if (next_fetch) begin
        rd_req  <= 1'b1;
        rd_addr <= rd_addr + 20'h00001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      miso   <= 1'b0;
      tx_q   <= 8'h00;
      obit_q <= 3'h0;
    end else if (cs_fall) begin
      obit_q <= 3'h0;
    end else if (sclk_fall && state_q == pfsfe_pkg::st_read) begin
      obit_q <= obit_q + 3'h1;
      if (obit_q == 3'h0) begin
        miso <= rdbuf_q[7];
        tx_q <= {rdbuf_q[6:0], 1'b0};
      end else begin
        miso <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // driven only while this device is selected, so a shared line stays free
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= !s_cs_b && normal && state_q == pfsfe_pkg::st_read;
    end
  end

  // ========================================================================
  // command execution at deselect
  logic exec;
  logic prot;
  logic modify_ok;
  logic start_pw;
  logic start_pp;
  logic start_pe;
  logic start_se;
  logic start_any;
  logic cyc_end;

  assign exec      = cs_rise && normal && bit_q == 3'h0 &&
                     state_q == pfsfe_pkg::st_data && !busy;
  // sector 0 is exactly the protected pages, so sector erase is covered too
  assign prot      = !s_wp_b && (addr_q[19:8] < pfsfe_pkg::PROT_PAGE_LIMIT);
  assign modify_ok = write_permit_latch && !prot;
  assign start_pw  = exec && modify_ok && cmd_q == pfsfe_pkg::OP_PAGE_WRITE &&
                     nbytes_q != 9'h000;
  assign start_pp  = exec && modify_ok && cmd_q == pfsfe_pkg::OP_PAGE_PROGRAM &&
                     nbytes_q != 9'h000;
  assign start_pe  = exec && modify_ok && cmd_q == pfsfe_pkg::OP_PAGE_ERASE;
  assign start_se  = exec && modify_ok && cmd_q == pfsfe_pkg::OP_SECTOR_ERASE;
  assign start_any = start_pw || start_pp || start_pe || start_se;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_permit_latch <= 1'b0;
    end else if (!normal) begin
      write_permit_latch <= 1'b0;
    end else if (exec && cmd_q == pfsfe_pkg::OP_PERMIT_SET) begin
      write_permit_latch <= 1'b1;
    end else if (cyc_end || (exec && cmd_q == pfsfe_pkg::OP_PERMIT_CLR)) begin
      write_permit_latch <= 1'b0;
    end
  end

  // ========================================================================
  // internal erase/program cycle
  pfsfe_pkg::pfsfe_cycle_type     cyc_q;
  logic [pfsfe_pkg::TIMER_W-1:0]  timer_q;
  logic                           chain_q;
  localparam logic [pfsfe_pkg::TIMER_W-1:0] ERASE_LAST   = pfsfe_pkg::TIMER_W'(ERASE_CLKS - 1);
  localparam logic [pfsfe_pkg::TIMER_W-1:0] PROGRAM_LAST = pfsfe_pkg::TIMER_W'(PROGRAM_CLKS - 1);

  assign cyc_end = normal && cyc_q != pfsfe_pkg::cy_idle && timer_q == '0 &&
                   !(cyc_q == pfsfe_pkg::cy_erase && chain_q);
  assign cyc_erase   = cyc_q[pfsfe_pkg::CY_ERASE_BIT];
  assign cyc_program = cyc_q[pfsfe_pkg::CY_PROGRAM_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q      <= pfsfe_pkg::cy_idle;
      timer_q    <= '0;
      chain_q    <= 1'b0;
      cyc_sector <= 1'b0;
      cyc_page   <= 12'h000;
    end else if (!normal) begin
      cyc_q <= pfsfe_pkg::cy_idle;
    end else begin
      unique case (cyc_q)
        pfsfe_pkg::cy_idle: begin
          if (start_any) begin
            cyc_q      <= start_pp ? pfsfe_pkg::cy_program : pfsfe_pkg::cy_erase;
            timer_q    <= start_pp ? PROGRAM_LAST : ERASE_LAST;
            chain_q    <= start_pw;
            cyc_sector <= start_se;
            cyc_page   <= addr_q[19:8];
          end
        end
        pfsfe_pkg::cy_erase: begin
          if (timer_q != '0) begin
            timer_q <= timer_q - 1'b1;
          end else if (chain_q) begin
            cyc_q   <= pfsfe_pkg::cy_program;
            timer_q <= PROGRAM_LAST;
            chain_q <= 1'b0;
          end else begin
            cyc_q <= pfsfe_pkg::cy_idle;
          end
        end
        pfsfe_pkg::cy_program: begin
          if (timer_q != '0) begin
            timer_q <= timer_q - 1'b1;
          end else begin
            cyc_q <= pfsfe_pkg::cy_idle;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // power state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy      <= 1'b0;
      cyc_abort <= 1'b0;
      active    <= 1'b0;
      standby   <= 1'b1;
    end else begin
      cyc_abort <= !normal && cyc_q != pfsfe_pkg::cy_idle;
      if (!normal || cyc_end) begin
        busy <= 1'b0;
      end else if (start_any) begin
        busy <= 1'b1;
      end
      active  <= !s_cs_b || busy || start_any;
      standby <= s_cs_b && !busy && !start_any;
    end
  end

  // ========================================================================
  // checks
  sequence s_erase_last;
    cyc_q == pfsfe_pkg::cy_erase && chain_q && timer_q == '0;
  endsequence

  sequence s_program_run;
    cyc_q == pfsfe_pkg::cy_program && timer_q == PROGRAM_LAST;
  endsequence

  a_oe_deselect: assert property (@(posedge clk) disable iff (!rst_b)
    s_cs_b |=> !miso_oe)
    else $error("output driven while deselected");

  a_oe_hw_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !s_hrst_b |=> !miso_oe)
    else $error("output driven during reset mode");

  a_miso_fall_only: assert property (@(posedge clk) disable iff (!rst_b)
    !sclk_fall |=> $stable(miso))
    else $error("output changed without a falling clock");

  a_abort_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    (!s_hrst_b && cyc_q != pfsfe_pkg::cy_idle) |=> (cyc_q == pfsfe_pkg::cy_idle && cyc_abort))
    else $error("reset did not abort the cycle");

  a_protect_low: assert property (@(posedge clk) disable iff (!rst_b)
    (exec && prot) |=> cyc_q == pfsfe_pkg::cy_idle)
    else $error("protected page was modified");

  a_standby_busy: assert property (@(posedge clk) disable iff (!rst_b)
    (busy || start_any) |=> !standby)
    else $error("standby entered during an internal cycle");

  a_active_select: assert property (@(posedge clk) disable iff (!rst_b)
    !s_cs_b |=> active && !standby)
    else $error("selected device not active");

  a_unarmed_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (!armed_q && !cs_fall) |=> state_q == pfsfe_pkg::st_idle)
    else $error("frame started before first select edge");

  a_write_chain: assert property (@(posedge clk) disable iff (!rst_b || !s_hrst_b)
    s_erase_last |=> s_program_run)
    else $error("page write did not program after erase");

  a_latch_clear: assert property (@(posedge clk) disable iff (!rst_b)
    cyc_end |=> !write_permit_latch ##1 !busy)
    else $error("permit latch kept after cycle end");

  a_align_refuse: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_rise && bit_q != 3'h0 && !busy) |=> cyc_q == pfsfe_pkg::cy_idle)
    else $error("unaligned command executed");

  a_start_latch: assert property (@(posedge clk) disable iff (!rst_b)
    (cyc_q == pfsfe_pkg::cy_idle && !write_permit_latch) |=> cyc_q == pfsfe_pkg::cy_idle)
    else $error("cycle started without permit latch");

endmodule

`default_nettype wire
